// [logic/or_move_decoder.v]
// OR, move, pointer-load and file-to-file move executor with AHB-Lite port
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "or_move_consts.vh"

module or_move_decoder
#(
	parameter AW = 12 // Data space address width
)
(
	input  wire          hclk,       // Clock, 10 MHz
	input  wire          hresetn,    // Async reset, active low
	input  wire          hsel,       // Slave select
	input  wire [31:0]   haddr,      // Byte address
	input  wire [1:0]    htrans,     // Transfer type
	input  wire          hwrite,     // Write strobe
	input  wire [2:0]    hsize,      // Transfer size (word only)
	input  wire          hready,     // Bus ready in
	input  wire [31:0]   hwdata,     // Write data
	output reg  [31:0]   hrdata,     // Read data
	output reg           hreadyout,  // Slave ready
	output reg           hresp,      // Always OKAY
	output reg  [AW-1:0] mem_addr,   // Data memory address
	output reg           mem_rd,     // Data memory read strobe
	input  wire [7:0]    mem_rdata,  // Data memory read value
	output reg           mem_wr,     // Data memory write strobe
	output reg  [7:0]    mem_wdata,  // Data memory write value
	input  wire [7:0]    bank_select_reg, // Bank select register
	input  wire [7:0]    ptr2_low,   // Pointer 2 low, index base
	input  wire [7:0]    ptr2_high,  // Pointer 2 high, index base
	output reg           ptr_wr,     // Pointer write strobe
	output reg  [1:0]    ptr_sel,    // Pointer number 0..2
	output reg           ptr_hi,     // 1: high part, 0: low byte
	output reg  [7:0]    ptr_data    // Pointer write value
);

	// ----------------------------------------------------------------------
	// Execution states
	// ----------------------------------------------------------------------
	localparam ST_IDLE  = 2'h0; // Waiting for an instruction
	localparam ST_ONE   = 2'h1; // First instruction cycle
	localparam ST_TWO   = 2'h2; // Second cycle of two-word forms

	reg  [1:0]  state_ff;          // Execution state
	reg  [1:0]  nxt_state;         // Next state
	reg  [15:0] word1_ff;          // First instruction word
	reg  [15:0] word2_ff;          // Second instruction word
	reg  [7:0]  wreg_ff;           // Working register
	reg  [7:0]  opnd_ff;           // Operand read in Q2
	reg  [7:0]  result_ff;         // Result formed in Q3
	reg         neg_ff;            // Negative flag
	reg         zero_ff;           // Zero flag
	reg         ext_ff;            // Extended set enable
	reg         baddst_ff;         // Forbidden move target seen
	reg         start_ff;          // Instruction submitted
	wire [1:0]  phase;             // Quarter phase
	wire        q4_end;            // Last quarter of a cycle
	reg         bus_wr_ff;         // Pending bus write
	reg  [3:0]  bus_addr_ff;       // Latched bus address

	// Opcode classification of the first word
	wire is_or_lit = word1_ff[15:8] == `OP_OR_LIT;
	wire is_or_f   = word1_ff[15:10] == `OP6_OR_FILE;
	wire is_move_f = word1_ff[15:10] == `OP6_MOVE_F;
	wire is_f2f    = word1_ff[15:12] == `OP4_F2F;
	wire is_ptr_ld = (word1_ff[15:10] == `OP6_PTR_LOAD) &&
	                 (word1_ff[7:6] == `PTR_LOAD_TAG);
	wire two_word  = is_f2f || is_ptr_ld;

	// ----------------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------------
	// Effective address of a byte-oriented file field
	function [AW-1:0] file_addr;
		input [7:0] f;
		input       a;
		input       ext;
		input [7:0] bank_sel;
		input [15:0] base;
		begin
			if (a)
				file_addr = {bank_sel[3:0], f};
			else if (ext && f <= `IDX_LIMIT)
				file_addr = base[AW-1:0] + {4'h0, f};
			else if (f < `ACCESS_SPLIT)
				file_addr = {4'h0, f};
			else
				file_addr = {`ACCESS_HI, f};
		end
	endfunction

	// Flags for a result: {negative, zero}
	function [1:0] nz_of;
		input [7:0] v;
		begin
			nz_of = {v[7], v == 8'h00};
		end
	endfunction

	wire [AW-1:0] byte_addr = file_addr(word1_ff[7:0], word1_ff[8], ext_ff,
	                                    bank_select_reg,
	                                    {ptr2_high, ptr2_low});
	wire [AW-1:0] src_addr  = word1_ff[11:0];
	wire [AW-1:0] dst_addr  = word2_ff[11:0];
	wire          dest_f    = word1_ff[9];
	wire          forbidden = (dst_addr == `ADDR_PROG_LO) ||
	                          (dst_addr >= `ADDR_STK_LO &&
	                           dst_addr <= `ADDR_STK_HI);

	// ----------------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------------
	quarter_phase u_phase
	(
		.hclk     (hclk),
		.hresetn  (hresetn),
		.run      (state_ff != ST_IDLE),
		.phase_ff (phase),
		.q4_end   (q4_end)
	);

	// ----------------------------------------------------------------------
	// State machine
	// ----------------------------------------------------------------------
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (start_ff)
					nxt_state = ST_ONE;
			ST_ONE:
				if (q4_end)
					nxt_state = two_word ? ST_TWO : ST_IDLE;
			ST_TWO:
				if (q4_end)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// ----------------------------------------------------------------------
	// Datapath: quarter-phase actions
	// ----------------------------------------------------------------------
	// Operand sampled in Q2, result in Q3, write-back in Q4
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wreg_ff   <= 8'h00;
			opnd_ff   <= 8'h00;
			result_ff <= 8'h00;
			neg_ff    <= 1'b0;
			zero_ff   <= 1'b0;
			baddst_ff <= 1'b0;
		end
		else if (bus_wr_ff && bus_addr_ff == `REG_WREG && state_ff == ST_IDLE)
			wreg_ff <= hwdata[7:0];
		else if (state_ff == ST_ONE)
		begin
			case (phase)
				`QPH_READ:
					if (is_or_lit)
						opnd_ff <= word1_ff[7:0];
					else if (is_f2f && src_addr == `ADDR_WREG)
						opnd_ff <= wreg_ff;
					else
						opnd_ff <= mem_rdata;
				`QPH_PROCESS:
					if (is_or_lit || is_or_f)
						result_ff <= wreg_ff | opnd_ff;
					else
						result_ff <= opnd_ff;
				`QPH_WRITE:
					if (is_or_lit || is_or_f || is_move_f)
					begin
						{neg_ff, zero_ff} <= nz_of(result_ff);
						if (is_or_lit || !dest_f)
							wreg_ff <= result_ff;
					end
				default:
					opnd_ff <= opnd_ff;
			endcase
		end
		else if (state_ff == ST_TWO && q4_end && is_f2f)
		begin
			// Flags untouched; only W and baddst_ff may change here
			if (dst_addr == `ADDR_WREG)
				wreg_ff <= result_ff;
			baddst_ff <= forbidden;
		end
	end

	// ----------------------------------------------------------------------
	// Data memory and pointer strobes (registered outputs)
	// ----------------------------------------------------------------------
	// Strobes are asserted one clock ahead so they stand during the quarter
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mem_addr  <= {AW{1'b0}};
			mem_rd    <= 1'b0;
			mem_wr    <= 1'b0;
			mem_wdata <= 8'h00;
			ptr_wr    <= 1'b0;
			ptr_sel   <= 2'h0;
			ptr_hi    <= 1'b0;
			ptr_data  <= 8'h00;
		end
		else
		begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			ptr_wr <= 1'b0;
			if (state_ff == ST_ONE && phase == `QPH_DECODE)
			begin
				// Read strobe covers Q2; no read for literal forms
				mem_addr <= is_f2f ? src_addr : byte_addr;
				mem_rd   <= (is_or_f || is_move_f) ||
				            (is_f2f && src_addr != `ADDR_WREG);
			end
			else if (state_ff == ST_ONE && phase == `QPH_PROCESS)
			begin
				// File write-back in Q4 when destination bit is set.
				// Built from the operand: result_ff is only formed at
				// this same edge and would still hold the last result
				mem_addr  <= byte_addr;
				mem_wdata <= is_or_f ? (wreg_ff | opnd_ff) : opnd_ff;
				mem_wr    <= (is_or_f || is_move_f) && dest_f;
				if (is_ptr_ld && word1_ff[5:4] <= `PTR_MAX)
				begin
					ptr_wr   <= 1'b1;
					ptr_sel  <= word1_ff[5:4];
					ptr_hi   <= 1'b1;
					ptr_data <= {4'h0, word1_ff[3:0]};
				end
			end
			else if (state_ff == ST_TWO && phase == `QPH_PROCESS)
			begin
				// Second cycle: no read, write only in Q4
				mem_addr  <= dst_addr;
				mem_wdata <= result_ff;
				mem_wr    <= is_f2f && dst_addr != `ADDR_WREG;
				if (is_ptr_ld && word1_ff[5:4] <= `PTR_MAX)
				begin
					ptr_wr   <= 1'b1;
					ptr_sel  <= word1_ff[5:4];
					ptr_hi   <= 1'b0;
					ptr_data <= word2_ff[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------------
	// Zero wait states; instructions are written while idle only
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_wr_ff   <= 1'b0;
			bus_addr_ff <= 4'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h0000_0000;
		end
		else
		begin
			hresp     <= 1'b0;
			hreadyout <= 1'b1;
			if (hready)
			begin
				// Upper bits must be clear, or a write would alias
				bus_wr_ff   <= hsel && htrans == `HTRANS_NSEQ && hwrite
				               && haddr[31:4] == 28'h0000000;
				bus_addr_ff <= haddr[3:0];
			end
			else
				bus_wr_ff <= 1'b0;
			if (hready && hsel && htrans == `HTRANS_NSEQ && !hwrite)
			begin
				case (haddr)
					{28'h0000000, `REG_CTRL}:
						hrdata <= {31'h0, ext_ff};
					{28'h0000000, `REG_INSTR}:
						hrdata <= {word2_ff, word1_ff};
					{28'h0000000, `REG_STATUS}:
						hrdata <= {28'h0, baddst_ff, zero_ff, neg_ff,
						           state_ff != ST_IDLE};
					{28'h0000000, `REG_WREG}:
						hrdata <= {24'h0, wreg_ff};
					default:
						hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control and instruction registers written in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_ff   <= 1'b0;
			word1_ff <= 16'h0000;
			word2_ff <= 16'h0000;
			start_ff <= 1'b0;
		end
		else
		begin
			start_ff <= 1'b0;
			if (bus_wr_ff && bus_addr_ff == `REG_CTRL)
				ext_ff <= hwdata[`CTRL_EXT_BIT];
			if (bus_wr_ff && bus_addr_ff == `REG_INSTR && state_ff == ST_IDLE
			    && !start_ff)
			begin
				word1_ff <= hwdata[15:0];
				word2_ff <= hwdata[31:16];
				start_ff <= 1'b1;
			end
		end
	end

endmodule

// [logic/or_move_consts.vh]
// Constants for the OR, move and pointer-load instruction decoder
`ifndef OR_MOVE_CONSTS_VH
`define OR_MOVE_CONSTS_VH

// --------------------------------------------------------------------------
// Quarter phases of the instruction cycle
// --------------------------------------------------------------------------
`define QPH_DECODE   2'h0
`define QPH_READ     2'h1
`define QPH_PROCESS  2'h2
`define QPH_WRITE    2'h3

// --------------------------------------------------------------------------
// Opcode fields
// --------------------------------------------------------------------------
`define OP_OR_LIT    8'h09
`define OP6_OR_FILE  6'h04
`define OP6_MOVE_F   6'h14
`define OP4_F2F      4'hC
`define OP4_SECOND   4'hF
`define OP6_PTR_LOAD 6'h3B
`define PTR_2ND_HI   8'hF0
`define PTR_LOAD_TAG 2'h0
`define PTR_MAX      2'h2

// --------------------------------------------------------------------------
// Addressing
// --------------------------------------------------------------------------
`define IDX_LIMIT    8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HI    4'hF
`define ADDR_WREG    12'hFE8
`define ADDR_PROG_LO 12'hFF9
`define ADDR_STK_LO  12'hFFD
`define ADDR_STK_HI  12'hFFF

// --------------------------------------------------------------------------
// Register bus map (byte addresses)
// --------------------------------------------------------------------------
`define REG_CTRL     4'h0
`define REG_INSTR    4'h4
`define REG_STATUS   4'h8
`define REG_WREG     4'hC
`define CTRL_EXT_BIT 0
`define STAT_BUSY    0
`define STAT_NEG     1
`define STAT_ZERO    2
`define STAT_BADDST  3
`define HTRANS_NSEQ  2'h2

`endif

// [logic/quarter_phase.v]
// Quarter-phase sequencer deriving Q1..Q4 enables from hclk
`timescale 1ns/1ps
`include "or_move_consts.vh"

module quarter_phase
(
	input  wire       hclk,     // System clock
	input  wire       hresetn,  // Asynchronous reset, active low
	input  wire       run,      // Advance phases while high
	output reg  [1:0] phase_ff, // Current quarter phase
	output reg        q4_end    // Pulse in the last quarter
);

	// ----------------------------------------------------------------------
	// Phase counter
	// ----------------------------------------------------------------------
	// Wraps Q4 back to Q1; holds at Q1 while idle so a cycle starts clean
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_ff <= `QPH_DECODE;
		else if (run)
			phase_ff <= phase_ff + 2'h1;
		else
			phase_ff <= `QPH_DECODE;
	end

	// Combinational end-of-cycle marker
	always @*
	begin
		q4_end = run && (phase_ff == `QPH_WRITE);
	end

endmodule

// [tb/or_move_checker.sv]
// Port-level assertions for the OR, move and pointer-load executor
`timescale 1ns/1ps

module or_move_checker
(
	input wire        hclk,      // Clock
	input wire        hresetn,   // Reset, active low
	input wire        hsel,      // Slave select
	input wire [1:0]  htrans,    // Transfer type
	input wire        hwrite,    // Write strobe
	input wire        hready,    // Bus ready
	input wire [31:0] hrdata,    // Read data
	input wire        hreadyout, // Slave ready
	input wire        hresp,     // Response
	input wire        mem_rd,    // Memory read strobe
	input wire        mem_wr,    // Memory write strobe
	input wire        ptr_wr,    // Pointer write strobe
	input wire [1:0]  ptr_sel,   // Pointer number
	input wire        ptr_hi,    // High part select
	input wire [7:0]  ptr_data   // Pointer value
);
	// ------------------------------------------------------------------
	// One clock domain, so one default clocking
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	a_zero_wait: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	// Read data only moves after a read address phase
	a_rdata_hold: assert property
		(!$past(hsel && hready && htrans == 2'h2 && !hwrite)
		|-> $stable(hrdata))
		else $error("hrdata changed without read");
	a_read_quarter: assert property (mem_rd |=> !mem_rd [*3])
		else $error("read more than once per cycle");
	a_write_later: assert property (mem_rd |=> !mem_wr)
		else $error("write in process quarter");
	a_write_quarter: assert property (mem_wr |=> !mem_wr [*3])
		else $error("write more than once per cycle");
	// High part lands one instruction cycle before the low byte
	a_ptr_pair: assert property (ptr_wr && ptr_hi |-> ##4
		(ptr_wr && !ptr_hi && ptr_sel == $past(ptr_sel, 4)))
		else $error("pointer low byte missing");
	a_ptr_range: assert property (ptr_wr |-> ptr_sel <= 2'h2
		&& (!ptr_hi || ptr_data[7:4] == 4'h0))
		else $error("pointer number or high part bad");
	a_ptr_quiet: assert property (ptr_wr |-> !mem_rd && !mem_wr)
		else $error("pointer load touched memory");
endmodule

bind or_move_decoder or_move_checker chk_u
(
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .ptr_wr(ptr_wr), .ptr_sel(ptr_sel),
	.ptr_hi(ptr_hi), .ptr_data(ptr_data)
);

// [tb/tb.sv]
// Self-checking bench for the OR, move and pointer-load executor
`timescale 1ns/1ps
`include "or_move_consts.vh"

module tb;
	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	reg         hclk;      // Bus clock
	reg         hresetn;   // Reset, active low
	reg  [31:0] haddr;     // Bus address
	reg  [1:0]  htrans;    // Transfer type
	reg         hwrite;    // Write strobe
	reg  [31:0] hwdata;    // Write data
	reg  [7:0]  bank_sel;  // Bank select
	reg  [15:0] ptr2;      // Index base
	wire [31:0] hrdata;    // Read data
	wire        rdy;       // Slave ready, also bus ready
	wire [11:0] mem_addr;  // Memory address
	wire        mem_rd;    // Memory read strobe
	wire        mem_wr;    // Memory write strobe
	wire [7:0]  mem_wdata; // Memory write value
	wire        ptr_wr;    // Pointer write strobe
	wire [1:0]  ptr_sel;   // Pointer number
	wire        ptr_hi;    // High part select
	wire [7:0]  ptr_data;  // Pointer value
	reg  [7:0]  mem [0:4095]; // Data space model
	reg  [10:0] plog [0:7];   // Pointer writes seen
	integer     np;        // Pointer write count
	integer     nrd;       // Memory read count
	integer     err_total; // Mismatches
	integer     n_checks;  // Comparisons
	localparam [31:0] A_CTRL = `REG_CTRL;
	localparam [31:0] A_INSTR = `REG_INSTR;
	localparam [31:0] A_STAT = `REG_STATUS;
	localparam [31:0] A_W = `REG_WREG;

	// Single slave: its ready is the bus ready; word transfers only
	or_move_decoder dut_u
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(rdy),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(rdy), .hresp(),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem[mem_addr]),
		.mem_wr(mem_wr), .mem_wdata(mem_wdata), .bank_select_reg(bank_sel),
		.ptr2_low(ptr2[7:0]), .ptr2_high(ptr2[15:8]), .ptr_wr(ptr_wr),
		.ptr_sel(ptr_sel), .ptr_hi(ptr_hi), .ptr_data(ptr_data)
	);

	always #50 hclk = ~hclk;

	// Memory writes, read count and pointer log
	always @(posedge hclk)
	begin
		if (mem_wr === 1'b1)
			mem[mem_addr] <= mem_wdata;
		if (mem_rd === 1'b1)
			nrd <= nrd + 1;
		if (ptr_wr === 1'b1)
		begin
			plog[np[2:0]] <= {ptr_sel, ptr_hi, ptr_data};
			np <= np + 1;
		end
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp)
			begin
				err_total = err_total + 1;
				$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask

	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", n_checks, err_total);
			if (err_total == 0 && n_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// Bounded wait for hready sampled high
	task wait_rdy;
		integer i;
		begin
			i = 0;
			@(posedge hclk);
			while (rdy !== 1'b1 && i < 20)
			begin
				@(posedge hclk);
				i = i + 1;
			end
			if (i >= 20)
			begin
				err_total = err_total + 1;
				tally_and_finish;
			end
		end
	endtask

	task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
		begin
			haddr <= a;
			hwrite <= w;
			htrans <= 2'h2;
			wait_rdy;
			htrans <= 2'h0;
			hwdata <= d;
			wait_rdy;
			q = hrdata;
		end
	endtask

	task rd_chk(input string nm, input [31:0] a, input [31:0] exp);
		reg [31:0] q;
		begin
			xfer(1'b0, a, 32'h0, q);
			chk(nm, q, exp);
		end
	endtask

	task wr(input [31:0] a, input [31:0] d);
		reg [31:0] q;
		begin
			xfer(1'b1, a, d, q);
		end
	endtask

	// Busy rises two edges after the write, so polling waits for it
	task exec(input [31:0] w);
		integer i;
		reg [31:0] q;
		begin
			wr(A_INSTR, w);
			repeat (2) @(posedge hclk);
			q = 32'h1;
			i = 0;
			while (q[0] !== 1'b0 && i < 30)
			begin
				xfer(1'b0, A_STAT, 32'h0, q);
				i = i + 1;
			end
			if (i >= 30)
			begin
				err_total = err_total + 1;
				tally_and_finish;
			end
		end
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task sc_regs;
		begin
			rd_chk("ctrl", A_CTRL, 32'h0);
			rd_chk("status", A_STAT, 32'h0);
			wr(32'h10, 32'hFF);
			rd_chk("unmapped", 32'h10, 32'h0);
			rd_chk("ctrl", A_CTRL, 32'h0);
		end
	endtask

	task sc_or;
		begin
			wr(A_W, 32'h9A);
			exec(32'h0935);
			rd_chk("w", A_W, 32'hBF);
			rd_chk("status", A_STAT, 32'h2);
			mem[12'h213] = 8'h13;
			wr(A_W, 32'h91);
			exec(32'h1113);
			rd_chk("w", A_W, 32'h93);
			chk("file", mem[12'h213], 8'h13);
			wr(A_W, 32'h44);
			exec(32'h1313);
			chk("file", mem[12'h213], 8'h57);
			rd_chk("w", A_W, 32'h44);
		end
	endtask

	task sc_move_file_register;
		begin
			mem[12'h022] = 8'h00;
			exec(32'h5022);
			rd_chk("w", A_W, 32'h0);
			rd_chk("status", A_STAT, 32'h4);
			mem[12'hF70] = 8'h80;
			exec(32'h5270);
			rd_chk("status", A_STAT, 32'h2);
			rd_chk("w", A_W, 32'h0);
			chk("file", mem[12'hF70], 8'h80);
			wr(A_CTRL, 32'h1);
			mem[12'h35F] = 8'h44;
			exec(32'h505F);
			rd_chk("w", A_W, 32'h44);
			mem[12'hF60] = 8'h01;
			exec(32'h5060);
			rd_chk("w", A_W, 32'h01);
			wr(A_CTRL, 32'h0);
		end
	endtask

	task sc_load_pointer_literal;
		reg [1:0]  f;
		reg [11:0] k;
		begin
			for (f = 2'h0; f <= 2'h2; f = f + 2'h1)
			begin
				k = 12'h3AB + {10'h0, f};
				np = 0;
				exec({8'hF0, k[7:0], 8'hEE, 2'h0, f, k[11:8]});
				chk("count", np, 32'h2);
				chk("high", plog[0], {f, 1'b1, 4'h0, k[11:8]});
				chk("low", plog[1], {f, 1'b0, k[7:0]});
			end
			// Pointer number 3 does not exist: nothing may be written
			np = 0;
			exec(32'hF0ABEE3F);
			chk("none", np, 32'h0);
		end
	endtask

	task sc_move_file_to_file;
		begin
			wr(A_W, 32'h0);
			exec(32'h0900);
			mem[12'h123] = 8'h33;
			nrd = 0;
			exec(32'hF456C123);
			chk("dest", mem[12'h456], 8'h33);
			chk("reads", nrd, 32'h1);
			rd_chk("status", A_STAT, 32'h4);
			exec(32'hFFE8C123);
			rd_chk("w", A_W, 32'h33);
			wr(A_W, 32'h5A);
			exec(32'hF200CFE8);
			chk("dest", mem[12'h200], 8'h5A);
			exec(32'hFFF9C123);
			rd_chk("status", A_STAT, 32'hC);
		end
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		bank_sel = 8'h02;
		ptr2 = 16'h0300;
		np = 0;
		nrd = 0;
		err_total = 0;
		n_checks = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		sc_regs;
		sc_or;
		sc_move_file_register;
		sc_load_pointer_literal;
		sc_move_file_to_file;
		tally_and_finish;
	end
endmodule
